/* File: design/xps_defines.svh */
// Register offsets, field positions, sizes and strobe timing of the pointer and expanded RAM block.
`ifndef XPS_DEFINES_SVH
`define XPS_DEFINES_SVH

`define XPS_AUXM_ADDR     8'h8E
`define XPS_AUXP_ADDR     8'hA2
`define XPS_PLOW_ADDR     8'h82
`define XPS_PHIGH_ADDR    8'h83
`define XPS_SFR_BIT       7

`define XPS_AUXM_STRETCH  5
`define XPS_AUXM_XRS_HI   3
`define XPS_AUXM_XRS_LO   2
`define XPS_AUXM_EXTERNAL_DATA_SELECT   1
`define XPS_AUXM_ALEMODE  0
`define XPS_AUXP_UFLAG    3
`define XPS_AUXP_ZERO     2
`define XPS_AUXP_SELECT   0

`define XPS_IRAM_DEPTH    256
`define XPS_EXPANDED_RAM_DEPTH    1024
`define XPS_EXPANDED_RAM_ABITS    10
`define XPS_PAGE_BITS     8

`define XPS_STRB_SHORT    5'd6
`define XPS_STRB_LONG     5'd30

`endif

/* File: design/xps_pkg.sv */
// Types shared by the pointer and expanded RAM block.
`include "xps_defines.svh"
package xps_pkg;

	typedef enum logic [2:0] {
		XPS_IDLE = 3'b000,
		XPS_ALE  = 3'b001,
		XPS_STRB = 3'b011,
		XPS_ENDC = 3'b010
	} xps_fsm_t;

	typedef struct packed {
		xps_fsm_t                                  state;
		logic [4:0]                                cnt;
		logic                                      cfg_done;
		logic                                      external_data_select;
		logic [1:0]                                xrs;
		logic                                      stretch;
		logic                                      ale_mode;
		logic                                      pointer_select;
		logic                                      uflag;
		logic [1:0][15:0]                          data_pointer;
		logic [`XPS_IRAM_DEPTH-1:0][7:0]           iram;
		logic [`XPS_EXPANDED_RAM_DEPTH-1:0][7:0]           expanded_ram;
		logic [7:0]                                acc_rdata;
		logic                                      acc_sfr;
		logic [7:0]                                mov_rdata;
		logic                                      mov_done;
		logic                                      bus_wr;
		logic [7:0]                                bus_data;
		logic [7:0]                                p0;
		logic                                      p0_oe;
		logic [7:0]                                p2;
		logic                                      wr_n;
		logic                                      rd_n;
		logic                                      ale;
	} xps_state_t;

endpackage

/* File: design/xps_expanded_ram_ptr.sv */
// Dual data pointer, internal data decode and expanded RAM / external bus router.
//
// Summary of operation
// R01 - Two 16-bit data pointers; select bit 0 of pointer control picks one.
// R02 - Pointer control bit 2 reads zero so increment toggles only the select.
// R03 - Software leaves reserved pointer control bits zero and ignores their read value.
// R04 - Expanded RAM holds 1024 bytes at external data addresses 0 to 3FFh.
// R05 - Internal locations 00h to 7Fh reachable directly and indirectly.
// R06 - Direct accesses at 80h to FFh go to function registers.
// R07 - Indirect accesses at 80h to FFh go to upper 128 RAM bytes.
// R08 - Upper RAM is storage separate from the function registers.
// R09 - Internal expanded RAM moves leave port 0, port 2 and strobes untouched.
// R10 - Register and pointer moves reach expanded RAM; above FFh only by pointer.
// R11 - Pointer moves above enabled size run an external multiplexed bus cycle.
// R12 - Size field hides upper expanded RAM; hidden addresses go external.
// R13 - External register moves drive 8-bit address multiplexed with data on port 0.
// R14 - External pointer moves put high byte on port 2, low byte on port 0.
// R15 - External moves pulse write strobe for writes, read strobe for reads.
// R16 - Stack reaches only the 256-byte internal RAM, never expanded RAM.
// R17 - With stretch set, strobes last 30 clock periods.
// R18 - External select bit chooses target; loaded from configuration after power-up.
// R19 - With stretch clear, the default, strobes last 6 clock periods.
// R20 - Pointer select comes up cleared after reset.
`timescale 1ns/1ps
`include "xps_defines.svh"
module xps_expanded_ram_ptr (
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	input  wire logic        cfg_external_data_select_i,
	input  wire logic [7:0]  acc_addr_i,
	input  wire logic        acc_indirect_i,
	input  wire logic        acc_wr_i,
	input  wire logic        acc_rd_i,
	input  wire logic [7:0]  acc_wdata_i,
	output logic      [7:0]  acc_rdata_o,
	output logic             acc_sfr_o,
	input  wire logic        ptr_inc_i,
	input  wire logic        mov_req_i,
	input  wire logic        mov_wr_i,
	input  wire logic        mov_via_ptr_i,
	input  wire logic [7:0]  mov_reg_addr_i,
	input  wire logic [7:0]  mov_wdata_i,
	output logic      [7:0]  mov_rdata_o,
	output logic             mov_done_o,
	input  wire logic [7:0]  p0_i,
	output logic      [7:0]  p0_o,
	output logic             p0_oe_o,
	output logic      [7:0]  p2_o,
	output logic             wr_n_o,
	output logic             rd_n_o,
	output logic             ale_o
);

	xps_pkg::xps_state_t st;
	xps_pkg::xps_state_t nxt;

	logic [15:0] sel_ptr;
	logic [15:0] mov_addr;
	logic        mov_int;
	logic        to_sfr;

	// True when the address falls inside the enabled part of the expanded RAM.
	function automatic logic in_expanded_ram(input logic [15:0] addr, input logic [1:0] size);
		logic [15:0] limit;
		limit = ({14'h0000, size} + 16'h0001) << `XPS_PAGE_BITS;
		return (addr < limit);
	endfunction

	// Read value of this block's function registers; reserved bits read as zero.
	function automatic logic [7:0] sfr_rd(input xps_pkg::xps_state_t s, input logic [7:0] a);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`XPS_AUXM_ADDR: begin
				r[`XPS_AUXM_STRETCH] = s.stretch;
				r[`XPS_AUXM_XRS_HI:`XPS_AUXM_XRS_LO] = s.xrs;
				r[`XPS_AUXM_EXTERNAL_DATA_SELECT] = s.external_data_select;
				r[`XPS_AUXM_ALEMODE] = s.ale_mode;
			end
			`XPS_AUXP_ADDR: begin
				r[`XPS_AUXP_UFLAG] = s.uflag;
				r[`XPS_AUXP_ZERO] = 1'b0; // [R02]
				r[`XPS_AUXP_SELECT] = s.pointer_select;
			end
			`XPS_PLOW_ADDR: begin
				r = s.data_pointer[s.pointer_select][7:0];
			end
			`XPS_PHIGH_ADDR: begin
				r = s.data_pointer[s.pointer_select][15:8];
			end
			default: begin
				r = 8'h00;
			end
		endcase
		return r;
	endfunction

	assign sel_ptr = st.data_pointer[st.pointer_select]; // [R01]
	// Register moves carry only an 8-bit address, so only pointer moves reach above FFh.
	assign mov_addr = mov_via_ptr_i ? sel_ptr : {8'h00, mov_reg_addr_i}; // [R10]
	assign mov_int = !st.external_data_select && in_expanded_ram(mov_addr, st.xrs); // [R12] [R18]
	// Stack accesses arrive as indirect accesses and so stay in internal RAM.
	assign to_sfr = !acc_indirect_i && acc_addr_i[`XPS_SFR_BIT]; // [R06] [R07] [R16]

	always_comb begin
		nxt = st;
		nxt.mov_done = 1'b0;
		nxt.acc_sfr = 1'b0;

		if (!st.cfg_done) begin
			nxt.external_data_select = cfg_external_data_select_i; // [R18]
			nxt.cfg_done = 1'b1;
		end

		if (ptr_inc_i) begin
			nxt.data_pointer[st.pointer_select] = sel_ptr + 16'h0001;
		end

		if (acc_wr_i) begin
			if (to_sfr) begin
				case (acc_addr_i)
					`XPS_AUXM_ADDR: begin
						nxt.stretch = acc_wdata_i[`XPS_AUXM_STRETCH];
						nxt.xrs = acc_wdata_i[`XPS_AUXM_XRS_HI:`XPS_AUXM_XRS_LO];
						nxt.external_data_select = acc_wdata_i[`XPS_AUXM_EXTERNAL_DATA_SELECT];
						nxt.ale_mode = acc_wdata_i[`XPS_AUXM_ALEMODE];
					end
					`XPS_AUXP_ADDR: begin
						nxt.pointer_select = acc_wdata_i[`XPS_AUXP_SELECT]; // [R01]
						nxt.uflag = acc_wdata_i[`XPS_AUXP_UFLAG]; // [R02]
					end
					`XPS_PLOW_ADDR: begin
						nxt.data_pointer[st.pointer_select][7:0] = acc_wdata_i;
					end
					`XPS_PHIGH_ADDR: begin
						nxt.data_pointer[st.pointer_select][15:8] = acc_wdata_i;
					end
					default: begin
						nxt.pointer_select = st.pointer_select;
					end
				endcase
			end else begin
				nxt.iram[acc_addr_i] = acc_wdata_i; // [R05] [R07] [R08]
			end
		end

		if (acc_rd_i) begin
			nxt.acc_rdata = to_sfr ? sfr_rd(st, acc_addr_i) : st.iram[acc_addr_i]; // [R05] [R08]
			nxt.acc_sfr = to_sfr; // [R06]
		end

		case (st.state)
			xps_pkg::XPS_IDLE: begin
				if (mov_req_i) begin
					if (mov_int) begin
						// Internal moves touch no pin.
						if (mov_wr_i) begin
							nxt.expanded_ram[mov_addr[`XPS_EXPANDED_RAM_ABITS-1:0]] = mov_wdata_i; // [R04] [R09]
						end else begin
							nxt.mov_rdata = st.expanded_ram[mov_addr[`XPS_EXPANDED_RAM_ABITS-1:0]]; // [R04] [R09]
						end
						nxt.mov_done = 1'b1;
					end else begin
						nxt.state = xps_pkg::XPS_ALE; // [R11]
						nxt.ale = 1'b1;
						nxt.p0 = mov_addr[7:0]; // [R13] [R14]
						nxt.p0_oe = 1'b1;
						if (mov_via_ptr_i) begin
							nxt.p2 = mov_addr[15:8]; // [R14]
						end
						nxt.bus_wr = mov_wr_i;
						nxt.bus_data = mov_wdata_i;
						nxt.cnt = (st.stretch ? `XPS_STRB_LONG : `XPS_STRB_SHORT) - 5'd1; // [R17] [R19]
					end
				end
			end
			xps_pkg::XPS_ALE: begin
				nxt.ale = 1'b0;
				nxt.state = xps_pkg::XPS_STRB;
				if (st.bus_wr) begin
					nxt.wr_n = 1'b0; // [R15]
					nxt.p0 = st.bus_data;
				end else begin
					nxt.rd_n = 1'b0; // [R15]
					nxt.p0_oe = 1'b0;
				end
			end
			xps_pkg::XPS_STRB: begin
				if (st.cnt == 5'd0) begin
					nxt.wr_n = 1'b1;
					nxt.rd_n = 1'b1;
					if (!st.bus_wr) begin
						nxt.mov_rdata = p0_i;
					end
					nxt.state = xps_pkg::XPS_ENDC;
				end else begin
					nxt.cnt = st.cnt - 5'd1; // [R17] [R19]
				end
			end
			xps_pkg::XPS_ENDC: begin
				nxt.p0_oe = 1'b0;
				nxt.mov_done = 1'b1;
				nxt.state = xps_pkg::XPS_IDLE;
			end
			default: begin
				nxt.state = xps_pkg::XPS_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st <= '0; // [R20]
			st.wr_n <= 1'b1;
			st.rd_n <= 1'b1;
		end else begin
			st <= nxt;
		end
	end

	assign acc_rdata_o = st.acc_rdata;
	assign acc_sfr_o   = st.acc_sfr;
	assign mov_rdata_o = st.mov_rdata;
	assign mov_done_o  = st.mov_done;
	assign p0_o        = st.p0;
	assign p0_oe_o     = st.p0_oe;
	assign p2_o        = st.p2;
	assign wr_n_o      = st.wr_n;
	assign rd_n_o      = st.rd_n;
	assign ale_o       = st.ale;

	AST_SEL_FOLLOWS_WRITE: assert property ( // [R01]
		@(posedge mclk_i) disable iff (!resetn_i)
		acc_wr_i && to_sfr && acc_addr_i == `XPS_AUXP_ADDR
		|=> st.pointer_select == $past(acc_wdata_i[`XPS_AUXP_SELECT])
	) else $error("Pointer select did not follow the write.");

	AST_BIT2_ZERO: assert property ( // [R02]
		@(posedge mclk_i) disable iff (!resetn_i)
		acc_rd_i && to_sfr && acc_addr_i == `XPS_AUXP_ADDR
		|=> !acc_rdata_o[`XPS_AUXP_ZERO] && acc_rdata_o[`XPS_AUXP_SELECT] == $past(st.pointer_select)
	) else $error("Pointer control read back wrong.");

	AST_DIRECT_SFR: assert property ( // [R06]
		@(posedge mclk_i) disable iff (!resetn_i)
		acc_rd_i && !acc_indirect_i && acc_addr_i[`XPS_SFR_BIT] |=> acc_sfr_o
	) else $error("Direct upper access missed function registers.");

	AST_INDIRECT_RAM: assert property ( // [R07]
		@(posedge mclk_i) disable iff (!resetn_i)
		acc_rd_i && acc_indirect_i |=> !acc_sfr_o && acc_rdata_o == $past(st.iram[acc_addr_i])
	) else $error("Indirect access did not read RAM.");

	AST_INTERNAL_QUIET: assert property ( // [R09]
		@(posedge mclk_i) disable iff (!resetn_i)
		st.state == xps_pkg::XPS_IDLE && mov_req_i && mov_int
		|=> mov_done_o && !ale_o && wr_n_o && rd_n_o && !p0_oe_o && $stable(p2_o)
	) else $error("Internal move disturbed the bus.");

	AST_HIDDEN_EXTERNAL: assert property ( // [R12]
		@(posedge mclk_i) disable iff (!resetn_i)
		st.state == xps_pkg::XPS_IDLE && mov_req_i && !mov_int |=> ale_o ##1 !ale_o
	) else $error("Move outside enabled RAM ran no bus cycle.");

	AST_PTR_ADDRESS: assert property ( // [R14]
		@(posedge mclk_i) disable iff (!resetn_i)
		st.state == xps_pkg::XPS_IDLE && mov_req_i && !mov_int && mov_via_ptr_i
		|=> p2_o == $past(sel_ptr[15:8]) && p0_o == $past(sel_ptr[7:0]) && p0_oe_o
	) else $error("Pointer address not placed on the ports.");

	AST_STRB_SHORT: assert property ( // [R19]
		@(posedge mclk_i) disable iff (!resetn_i)
		$fell(wr_n_o & rd_n_o) && !st.stretch |-> !(wr_n_o & rd_n_o) [*6] ##1 (wr_n_o & rd_n_o)
	) else $error("Short strobe length wrong.");

	AST_STRB_LONG: assert property ( // [R17]
		@(posedge mclk_i) disable iff (!resetn_i)
		$fell(wr_n_o & rd_n_o) && st.stretch |-> ##29 !(wr_n_o & rd_n_o) ##1 (wr_n_o & rd_n_o)
	) else $error("Stretched strobe length wrong.");

	AST_WRITE_STROBE: assert property ( // [R15]
		@(posedge mclk_i) disable iff (!resetn_i)
		$fell(wr_n_o) |-> st.bus_wr && rd_n_o && p0_oe_o && p0_o == st.bus_data
	) else $error("Write strobe without write data.");

	AST_CFG_LOAD: assert property ( // [R18]
		@(posedge mclk_i) disable iff (!resetn_i)
		!st.cfg_done |=> st.external_data_select == $past(cfg_external_data_select_i)
	) else $error("External select not loaded from configuration.");

	AST_SEL_RESET: assert property ( // [R20]
		@(posedge mclk_i) disable iff (!resetn_i)
		!st.cfg_done |-> !st.pointer_select
	) else $error("Pointer select not cleared after reset.");

	AST_EXPANDED_RAM_WRITE: assert property ( // [R04]
		@(posedge mclk_i) disable iff (!resetn_i)
		st.state == xps_pkg::XPS_IDLE && mov_req_i && mov_int && mov_wr_i
		|=> st.expanded_ram[$past(mov_addr[`XPS_EXPANDED_RAM_ABITS-1:0])] == $past(mov_wdata_i)
	) else $error("Internal move write did not land in expanded RAM.");

	AST_EXPANDED_RAM_READ: assert property ( // [R10]
		@(posedge mclk_i) disable iff (!resetn_i)
		st.state == xps_pkg::XPS_IDLE && mov_req_i && mov_int && !mov_wr_i
		|=> mov_rdata_o == $past(st.expanded_ram[mov_addr[`XPS_EXPANDED_RAM_ABITS-1:0]])
	) else $error("Internal move read returned wrong data.");

	AST_LOWER_BOTH: assert property ( // [R05]
		@(posedge mclk_i) disable iff (!resetn_i)
		acc_rd_i && !acc_addr_i[`XPS_SFR_BIT] |=> !acc_sfr_o && acc_rdata_o == $past(st.iram[acc_addr_i])
	) else $error("Lower RAM access did not read RAM.");

	AST_SFR_KEEPS_RAM: assert property ( // [R08]
		@(posedge mclk_i) disable iff (!resetn_i)
		acc_wr_i && to_sfr |=> st.iram == $past(st.iram)
	) else $error("Function register write changed data RAM.");

	AST_EXPANDED_RAM_ONLY_MOVES: assert property ( // [R16]
		@(posedge mclk_i) disable iff (!resetn_i)
		!(st.state == xps_pkg::XPS_IDLE && mov_req_i && mov_int && mov_wr_i) |=> $stable(st.expanded_ram)
	) else $error("Expanded RAM changed without an internal move.");

	AST_REG_ADDRESS: assert property ( // [R13]
		@(posedge mclk_i) disable iff (!resetn_i)
		st.state == xps_pkg::XPS_IDLE && mov_req_i && !mov_int && !mov_via_ptr_i
		|=> p0_o == $past(mov_reg_addr_i) && p0_oe_o && $stable(p2_o)
	) else $error("Register move address not placed on port 0.");

	AST_READ_STROBE: assert property ( // [R15]
		@(posedge mclk_i) disable iff (!resetn_i)
		$fell(rd_n_o) |-> !st.bus_wr && wr_n_o && !p0_oe_o
	) else $error("Read strobe while driving port 0.");

	AST_EXT_DONE: assert property ( // [R11]
		@(posedge mclk_i) disable iff (!resetn_i)
		st.state == xps_pkg::XPS_IDLE && mov_req_i && !mov_int && !st.stretch |-> ##9 mov_done_o
	) else $error("External bus cycle did not complete in time.");

	AST_BUS_RELEASE: assert property ( // [R11]
		@(posedge mclk_i) disable iff (!resetn_i)
		st.state == xps_pkg::XPS_ENDC |=> !p0_oe_o && mov_done_o && wr_n_o && rd_n_o
	) else $error("Bus not released at the end of the cycle.");

endmodule

/* File: testbench/xps_ext_mem.sv */
// External memory model on the multiplexed port 0 / port 2 bus.
`timescale 1ns/1ps
module xps_ext_mem (
	input  wire logic       mclk_i,
	input  wire logic [7:0] port0_i,
	input  wire logic [7:0] port2_i,
	input  wire logic       wr_n_i,
	input  wire logic       rd_n_i,
	input  wire logic       ale_i,
	output logic      [7:0] port0_o
);
	logic [7:0]  mem [0:65535];
	logic [15:0] addr_q = 16'h0000;
	logic [7:0]  last_q = 8'h00;
	always @(posedge mclk_i) begin
		if (ale_i) begin
			addr_q <= {port2_i, port0_i};
		end
		if (!wr_n_i) begin
			mem[addr_q] <= port0_i;
		end
		if (!rd_n_i) begin
			last_q <= mem[addr_q];
		end
	end
	// A released bus shows the inverse of the last byte so stale data cannot pass.
	assign port0_o = !rd_n_i ? mem[addr_q] : ~last_q;
endmodule

/* File: testbench/tb_top.sv */
// Self-checking testbench of the pointer and expanded RAM block.
`timescale 1ns/1ps
module tb_top;
	logic mclk_i = 1'b0, resetn_i = 1'b0, cfg_external_data_select_i = 1'b0;
	logic [7:0] acc_addr_i = 8'h00, acc_wdata_i = 8'h00, mov_reg_addr_i = 8'h00, mov_wdata_i = 8'h00;
	logic acc_indirect_i = 1'b0, acc_wr_i = 1'b0, acc_rd_i = 1'b0, ptr_inc_i = 1'b0;
	logic mov_req_i = 1'b0, mov_wr_i = 1'b0, mov_via_ptr_i = 1'b0;
	logic [7:0] acc_rdata_o, mov_rdata_o, p0_i, p0_o, p2_o;
	logic acc_sfr_o, mov_done_o, p0_oe_o, wr_n_o, rd_n_o, ale_o;
	int n_fail = 0;
	int n_checks = 0;
	initial begin
		forever #10 mclk_i = ~mclk_i;
	end
	xps_expanded_ram_ptr i_xps_expanded_ram_ptr (.mclk_i(mclk_i), .resetn_i(resetn_i), .cfg_external_data_select_i(cfg_external_data_select_i),
		.acc_addr_i(acc_addr_i), .acc_indirect_i(acc_indirect_i), .acc_wr_i(acc_wr_i), .acc_rd_i(acc_rd_i),
		.acc_wdata_i(acc_wdata_i), .acc_rdata_o(acc_rdata_o), .acc_sfr_o(acc_sfr_o), .ptr_inc_i(ptr_inc_i),
		.mov_req_i(mov_req_i), .mov_wr_i(mov_wr_i), .mov_via_ptr_i(mov_via_ptr_i),
		.mov_reg_addr_i(mov_reg_addr_i), .mov_wdata_i(mov_wdata_i), .mov_rdata_o(mov_rdata_o),
		.mov_done_o(mov_done_o), .p0_i(p0_i), .p0_o(p0_o), .p0_oe_o(p0_oe_o), .p2_o(p2_o),
		.wr_n_o(wr_n_o), .rd_n_o(rd_n_o), .ale_o(ale_o));
	xps_ext_mem i_xps_ext_mem (.mclk_i(mclk_i), .port0_i(p0_o), .port2_i(p2_o), .wr_n_i(wr_n_o),
		.rd_n_i(rd_n_o), .ale_i(ale_o), .port0_o(p0_i));
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic acc_wr(input logic [7:0] a, input logic ind, input logic [7:0] d);
		@(posedge mclk_i);
		acc_addr_i <= a;
		acc_indirect_i <= ind;
		acc_wdata_i <= d;
		acc_wr_i <= 1'b1;
		@(posedge mclk_i);
		acc_wr_i <= 1'b0;
	endtask
	task automatic acc_rd(input logic [7:0] a, input logic ind, input logic [7:0] exp, input logic sfr);
		@(posedge mclk_i);
		acc_addr_i <= a;
		acc_indirect_i <= ind;
		acc_rd_i <= 1'b1;
		@(posedge mclk_i);
		acc_rd_i <= 1'b0;
		#1;
		check({8'h00, acc_rdata_o}, {8'h00, exp});
		check({15'h0000, acc_sfr_o}, {15'h0000, sfr});
	endtask
	task automatic set_ptr(input logic [15:0] v);
		acc_wr(8'h82, 1'b0, v[7:0]);
		acc_wr(8'h83, 1'b0, v[15:8]);
	endtask
	// Runs one move and compares strobe-low cycles, pin activity and read data.
	task automatic mov(input logic wr, input logic ptr, input logic [7:0] ra, input logic [7:0] d,
		input logic [15:0] n_strb);
		logic [15:0] n;
		logic        act;
		n = 16'h0000;
		act = 1'b0;
		@(posedge mclk_i);
		mov_req_i <= 1'b1;
		mov_wr_i <= wr;
		mov_via_ptr_i <= ptr;
		mov_reg_addr_i <= ra;
		mov_wdata_i <= d;
		@(posedge mclk_i);
		mov_req_i <= 1'b0;
		for (int i = 0; i < 40; i++) begin
			#1;
			if (!rd_n_o || !wr_n_o) n++;
			if (ale_o || p0_oe_o) act = 1'b1;
			if (mov_done_o === 1'b1) break;
			@(posedge mclk_i);
		end
		check({15'h0000, mov_done_o}, 16'h0001);
		check(n, n_strb);
		check({15'h0000, act}, {15'h0000, n_strb != 16'h0000});
		if (!wr) check({8'h00, mov_rdata_o}, {8'h00, d});
	endtask
	initial begin
		#200000;
		n_fail++;
		give_verdict();
	end
	initial begin
		repeat (12) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		acc_rd(8'hA2, 1'b0, 8'h00, 1'b1);
		acc_rd(8'h8E, 1'b0, 8'h00, 1'b1);
		acc_wr(8'hA2, 1'b0, 8'h0D);
		acc_rd(8'hA2, 1'b0, 8'h09, 1'b1);
		acc_wr(8'hA2, 1'b0, 8'h0C);
		acc_rd(8'hA2, 1'b0, 8'h08, 1'b1);
		acc_wr(8'hA2, 1'b0, 8'h00);
		set_ptr(16'h1234);
		acc_wr(8'hA2, 1'b0, 8'h01);
		set_ptr(16'hABCD);
		@(posedge mclk_i);
		ptr_inc_i <= 1'b1;
		@(posedge mclk_i);
		ptr_inc_i <= 1'b0;
		acc_rd(8'h82, 1'b0, 8'hCE, 1'b1);
		acc_wr(8'hA2, 1'b0, 8'h00);
		acc_rd(8'h82, 1'b0, 8'h34, 1'b1);
		acc_rd(8'h83, 1'b0, 8'h12, 1'b1);
		acc_wr(8'h90, 1'b1, 8'h55);
		acc_wr(8'h90, 1'b0, 8'hAA);
		acc_rd(8'h90, 1'b1, 8'h55, 1'b0);
		acc_rd(8'h90, 1'b0, 8'h00, 1'b1);
		acc_wr(8'h20, 1'b0, 8'h66);
		acc_rd(8'h20, 1'b1, 8'h66, 1'b0);
		mov(1'b1, 1'b0, 8'h40, 8'h77, 16'd0);
		set_ptr(16'h0040);
		mov(1'b0, 1'b1, 8'h00, 8'h77, 16'd0);
		set_ptr(16'h0300);
		mov(1'b1, 1'b1, 8'h00, 8'h5A, 16'd6);
		check({8'h00, i_xps_ext_mem.mem[16'h0300]}, 16'h005A);
		acc_wr(8'h8E, 1'b0, 8'h0C);
		mov(1'b1, 1'b1, 8'h00, 8'hA5, 16'd0);
		mov(1'b0, 1'b1, 8'h00, 8'hA5, 16'd0);
		acc_wr(8'h8E, 1'b0, 8'h2F);
		acc_rd(8'h8E, 1'b0, 8'h2F, 1'b1);
		mov(1'b0, 1'b1, 8'h00, 8'h5A, 16'd30);
		acc_wr(8'h8E, 1'b0, 8'h02);
		mov(1'b1, 1'b0, 8'h55, 8'h3C, 16'd6);
		mov(1'b0, 1'b0, 8'h55, 8'h3C, 16'd6);
		check(i_xps_ext_mem.addr_q, 16'h0355);
		// A second reset with the configuration bit set must load external select and clear the selection.
		acc_wr(8'hA2, 1'b0, 8'h01);
		@(posedge mclk_i);
		cfg_external_data_select_i <= 1'b1;
		resetn_i <= 1'b0;
		repeat (2) @(posedge mclk_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge mclk_i);
		acc_rd(8'hA2, 1'b0, 8'h00, 1'b1);
		acc_rd(8'h8E, 1'b0, 8'h02, 1'b1);
		mov(1'b1, 1'b1, 8'h00, 8'hC3, 16'd6);
		check({8'h00, i_xps_ext_mem.mem[16'h0000]}, 16'h00C3);
		give_verdict();
	end
endmodule
